// ---- design/lrd_ctrl.v ----
// limit evaluation and infrared remote disable controller with avalon-mm registers
`timescale 1ns/1ps
// Function
// R1 - limit disable telegram decoded with configurable polarity
// R2 - bus return mode deactivated: limit evaluation runs at once
// R3 - bus return mode activated: all limits start disabled
// R4 - restore mode: save limit disable state on bus fail, reload on return
// R5 - download mode deactivated: limit evaluation runs right after download
// R6 - download mode activated: limits held disabled after download
// R7 - remote commands accepted only when remote control is enabled
// R8 - remote commands act only on function block 1
// R9 - on, auto, off buttons masked by configured preset
// R10 - test button toggles walking test only when configured available
// R11 - remote disable telegram enables or disables all buttons together
// R12 - while remote disabled every remote command is rejected
// R13 - remote disable telegram decoded with configurable polarity
// R14 - bus return sets remote disable state from configuration
// R15 - restore mode: save remote disable on bus fail, reapply on return
// R16 - after download remote is released or disabled per configuration
// R17 - new limit values accepted even while evaluation is disabled
// R18 - limit disable set and cleared through its own input object
// R19 - unused disabling function holds inactive and ignores its telegrams
`include "lrd_map.vh"

module lrd_ctrl
(
    input  wire        sys_clk,
    input  wire        reset,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        ir_on,
    input  wire        ir_auto,
    input  wire        ir_off,
    input  wire        ir_test,
    output reg         limit_eval_enable,
    output reg         fb1_cmd_on,
    output reg         fb1_cmd_auto,
    output reg         fb1_cmd_off,
    output reg         walk_test
);

    // ------------------------------------------------------------------
    // button codes
    // ------------------------------------------------------------------
    localparam [1:0] btn_on   = 2'h0;
    localparam [1:0] btn_auto = 2'h1;
    localparam [1:0] btn_off  = 2'h2;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // polarity 0: value 1 disables; polarity 1: value 0 disables
    function decode_disable;
        input pol;
        input val;
        begin
            decode_disable = val ^ pol;
        end
    endfunction

    // unknown code 3 falls back to released, the safe operating state
    function return_state;
        input [1:0] mode;
        input       saved;
        begin
            case (mode)
                `LRD_RET_ACT:     return_state = 1'b1;
                `LRD_RET_RESTORE: return_state = saved;
                default:          return_state = 1'b0;
            endcase
        end
    endfunction

    function [7:0] lane;
        input [7:0] old_val;
        input [7:0] new_val;
        input       en;
        begin
            lane = en ? new_val : old_val;
        end
    endfunction

    // auto is never masked; preset code 3 behaves as all buttons
    function btn_allowed;
        input [1:0] preset;
        input [1:0] btn;
        begin
            case (preset)
                `LRD_PRE_ON_AUTO:  btn_allowed = (btn != btn_off);
                `LRD_PRE_AUTO_OFF: btn_allowed = (btn != btn_on);
                default:           btn_allowed = 1'b1;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg [`LRD_CFG_WIDTH-1:0]   cfg;
    reg [`LRD_LIMIT_WIDTH-1:0] limit_value;
    reg                        limit_disabled;
    reg                        limit_saved;
    reg                        ir_disabled;
    reg                        ir_saved;

    wire [31:0] cfg_word;
    wire [31:0] merged;
    wire        access;
    wire        commit;
    wire        cmd_hit;
    wire        lim_used;
    wire        ir_used;
    wire        ir_ok;
    wire [1:0]  ir_pre;
    wire        ev_fail;
    wire        ev_return;
    wire        ev_download;
    wire        ev_lim_tel;
    wire        ev_ir_tel;

    assign cfg_word = {{(32-`LRD_CFG_WIDTH){1'b0}}, cfg};
    assign merged   = {lane(cfg_word[31:24], avs_writedata[31:24], avs_byteenable[3]),
                       lane(cfg_word[23:16], avs_writedata[23:16], avs_byteenable[2]),
                       lane(cfg_word[15:8],  avs_writedata[15:8],  avs_byteenable[1]),
                       lane(cfg_word[7:0],   avs_writedata[7:0],   avs_byteenable[0])};
    assign access   = avs_read | avs_write;
    // a write takes effect only at the edge where waitrequest is seen low
    assign commit   = avs_write & ~avs_waitrequest;
    assign cmd_hit  = commit & (avs_address == `LRD_OFS_CMD) & avs_byteenable[0];
    assign ev_fail     = cmd_hit & avs_writedata[`LRD_CMD_BUS_FAIL];
    assign ev_return   = cmd_hit & avs_writedata[`LRD_CMD_BUS_RETURN];
    assign ev_download = cmd_hit & avs_writedata[`LRD_CMD_DOWNLOAD];
    assign ev_lim_tel  = cmd_hit & avs_writedata[`LRD_CMD_LIM_TEL];
    assign ev_ir_tel   = cmd_hit & avs_writedata[`LRD_CMD_IR_TEL];
    assign lim_used = cfg[`LRD_CFG_LIM_USED];
    assign ir_used  = cfg[`LRD_CFG_IR_USED];
    assign ir_pre   = cfg[`LRD_CFG_IR_PRE_HI:`LRD_CFG_IR_PRE_LO];
    assign ir_ok    = cfg[`LRD_CFG_IR_EN] & ~ir_disabled;                                    // [R7] [R12]

    // ------------------------------------------------------------------
    // avalon-mm slave: one wait state, then one cycle of waitrequest low
    // ------------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end
        else if (access & avs_waitrequest)
        begin
            avs_waitrequest <= 1'b0;
            if (avs_read)
            begin
                case (avs_address)
                    `LRD_OFS_CFG:         avs_readdata <= cfg_word;
                    `LRD_OFS_STATUS:      avs_readdata <= {27'h0000000, walk_test, ir_saved, limit_saved,
                                                           ir_disabled, limit_disabled};
                    `LRD_OFS_LIMIT_VALUE: avs_readdata <= {16'h0000, limit_value};
                    default:              avs_readdata <= 32'h00000000;
                endcase
            end
            else
            begin
                avs_readdata <= 32'h00000000;
            end
        end
        else
        begin
            avs_waitrequest <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // configuration and limit value registers
    // ------------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            cfg         <= `LRD_CFG_RESET;
            limit_value <= `LRD_LIMIT_RESET;
        end
        else if (commit)
        begin
            if (avs_address == `LRD_OFS_CFG)
            begin
                cfg <= merged[`LRD_CFG_WIDTH-1:0];
            end
            // limit presets are never gated by the disable state
            if (avs_address == `LRD_OFS_LIMIT_VALUE)                                         // [R17]
            begin
                limit_value <= {lane(limit_value[15:8], avs_writedata[15:8], avs_byteenable[1]),
                                lane(limit_value[7:0],  avs_writedata[7:0],  avs_byteenable[0])};
            end
        end
    end

    // ------------------------------------------------------------------
    // limit evaluation disable state
    // ------------------------------------------------------------------
    // priority: download, then bus return, then telegram
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            limit_disabled <= 1'b0;
            limit_saved    <= 1'b0;
        end
        else
        begin
            if (ev_fail)
            begin
                limit_saved <= limit_disabled;                                               // [R4]
            end
            if (~lim_used)
            begin
                limit_disabled <= 1'b0;                                                      // [R19]
            end
            else if (ev_download)
            begin
                limit_disabled <= cfg[`LRD_CFG_LIM_DL];                                      // [R5] [R6]
            end
            else if (ev_return)
            begin
                limit_disabled <= return_state(cfg[`LRD_CFG_LIM_RET_HI:`LRD_CFG_LIM_RET_LO],
                                               limit_saved);                                 // [R2] [R3] [R4]
            end
            else if (ev_lim_tel)                                                             // [R18]
            begin
                limit_disabled <= decode_disable(cfg[`LRD_CFG_LIM_POL],
                                                 avs_writedata[`LRD_CMD_LIM_VAL]);           // [R1]
            end
        end
    end

    // ------------------------------------------------------------------
    // remote control disable state
    // ------------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            ir_disabled <= 1'b0;
            ir_saved    <= 1'b0;
        end
        else
        begin
            if (ev_fail)
            begin
                ir_saved <= ir_disabled;                                                     // [R15]
            end
            if (~ir_used)
            begin
                ir_disabled <= 1'b0;                                                         // [R19]
            end
            else if (ev_download)
            begin
                ir_disabled <= cfg[`LRD_CFG_IR_DL];                                          // [R16]
            end
            else if (ev_return)
            begin
                ir_disabled <= return_state(cfg[`LRD_CFG_IR_RET_HI:`LRD_CFG_IR_RET_LO],
                                            ir_saved);                                       // [R14] [R15]
            end
            else if (ev_ir_tel)                                                              // [R11]
            begin
                ir_disabled <= decode_disable(cfg[`LRD_CFG_IR_POL],
                                              avs_writedata[`LRD_CMD_IR_VAL]);               // [R13]
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs toward function block 1 and the limit evaluator
    // ------------------------------------------------------------------
    // only block 1 has command outputs, so no other block can be reached
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            limit_eval_enable <= 1'b1;
            fb1_cmd_on        <= 1'b0;
            fb1_cmd_auto      <= 1'b0;
            fb1_cmd_off       <= 1'b0;
            walk_test         <= 1'b0;
        end
        else
        begin
            limit_eval_enable <= ~limit_disabled;                                            // [R2] [R3]
            fb1_cmd_on        <= ir_ok & ir_on & btn_allowed(ir_pre, btn_on);                // [R8] [R9]
            fb1_cmd_auto      <= ir_ok & ir_auto & btn_allowed(ir_pre, btn_auto);            // [R8] [R9]
            fb1_cmd_off       <= ir_ok & ir_off & btn_allowed(ir_pre, btn_off);              // [R8] [R9]
            if (ir_ok & ir_test & cfg[`LRD_CFG_IR_TEST])
            begin
                walk_test <= ~walk_test;                                                     // [R10]
            end
        end
    end

endmodule // lrd_ctrl

// ---- design/lrd_map.vh ----
// register map and field constants of the limit and remote disable controller
`ifndef LRD_MAP_VH
`define LRD_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define LRD_OFS_CFG         4'h0
`define LRD_OFS_CMD         4'h4
`define LRD_OFS_STATUS      4'h8
`define LRD_OFS_LIMIT_VALUE 4'hc

// ----------------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------------
`define LRD_CFG_LIM_USED    0
`define LRD_CFG_LIM_POL     1
`define LRD_CFG_LIM_RET_LO  2
`define LRD_CFG_LIM_RET_HI  3
`define LRD_CFG_LIM_DL      4
`define LRD_CFG_IR_EN       5
`define LRD_CFG_IR_PRE_LO   6
`define LRD_CFG_IR_PRE_HI   7
`define LRD_CFG_IR_TEST     8
`define LRD_CFG_IR_USED     9
`define LRD_CFG_IR_POL      10
`define LRD_CFG_IR_RET_LO   11
`define LRD_CFG_IR_RET_HI   12
`define LRD_CFG_IR_DL       13
`define LRD_CFG_WIDTH       14
`define LRD_CFG_RESET       14'h0000

// ----------------------------------------------------------------------
// command fields (write only; bits 1 and 3 carry telegram values, bits 0, 2, 4, 5 and 6 are events)
// ----------------------------------------------------------------------
`define LRD_CMD_LIM_TEL     0
`define LRD_CMD_LIM_VAL     1
`define LRD_CMD_IR_TEL      2
`define LRD_CMD_IR_VAL      3
`define LRD_CMD_BUS_FAIL    4
`define LRD_CMD_BUS_RETURN  5
`define LRD_CMD_DOWNLOAD    6

// ----------------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------------
`define LRD_RET_DEACT       2'h0
`define LRD_RET_ACT         2'h1
`define LRD_RET_RESTORE     2'h2
`define LRD_PRE_ALL         2'h0
`define LRD_PRE_ON_AUTO     2'h1
`define LRD_PRE_AUTO_OFF    2'h2
`define LRD_LIMIT_RESET     16'h03e8
`define LRD_LIMIT_WIDTH     16

`endif

// ---- test/lrd_ctrl_chk.sv ----
// port assertions for the limit and remote disable controller
`timescale 1ns/1ps
module lrd_ctrl_chk
(
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        ir_on,
    input wire logic        ir_auto,
    input wire logic        ir_off,
    input wire logic        ir_test,
    input wire logic        limit_eval_enable,
    input wire logic        fb1_cmd_on,
    input wire logic        fb1_cmd_auto,
    input wire logic        fb1_cmd_off,
    input wire logic        walk_test
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus access not answered after one wait state");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    on_cmd_a: assert property (fb1_cmd_on |-> $past(ir_on))
        else $error("on command without on button");
    auto_cmd_a: assert property (fb1_cmd_auto |-> $past(ir_auto))
        else $error("auto command without auto button");
    off_cmd_a: assert property (fb1_cmd_off |-> $past(ir_off))
        else $error("off command without off button");
    test_toggle_a: assert property ($changed(walk_test) |-> $past(ir_test))
        else $error("walking test changed without test button");
    lim_cause_a: assert property ($changed(limit_eval_enable) |-> $past(avs_write, 2) || $past(avs_write, 3))
        else $error("limit evaluation changed without a register write");
endmodule // lrd_ctrl_chk

bind lrd_ctrl lrd_ctrl_chk i_lrd_ctrl_chk (.sys_clk(sys_clk), .reset(reset), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .ir_on(ir_on), .ir_auto(ir_auto),
    .ir_off(ir_off), .ir_test(ir_test), .limit_eval_enable(limit_eval_enable), .fb1_cmd_on(fb1_cmd_on),
    .fb1_cmd_auto(fb1_cmd_auto), .fb1_cmd_off(fb1_cmd_off), .walk_test(walk_test));

// ---- test/lrd_ir_remote.sv ----
// infrared remote model: one event pulse per key press
`timescale 1ns/1ps
module lrd_ir_remote
(
    input wire logic       sys_clk,
    input wire logic [3:0] key,
    output logic           ir_on = 1'b0,
    output logic           ir_auto = 1'b0,
    output logic           ir_off = 1'b0,
    output logic           ir_test = 1'b0
);
    // a key held one cycle gives one decoded button event
    always @(posedge sys_clk)
        {ir_test, ir_off, ir_auto, ir_on} <= key;
endmodule // lrd_ir_remote

// ---- test/lrd_ctrl_tb.sv ----
// self-checking bench of the limit and remote disable controller
`timescale 1ns/1ps
`include "lrd_map.vh"
module lrd_ctrl_tb;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, ir_on, ir_auto, ir_off, ir_test, limit_eval_enable;
    wire         fb1_cmd_on, fb1_cmd_auto, fb1_cmd_off, walk_test;
    logic [3:0]  key = 4'h0;
    logic [63:0] rq[$];
    logic [2:0]  fq[$];
    logic [63:0] rnote = 64'h0;
    logic        ewalk = 1'b0;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    always #4 sys_clk = ~sys_clk;
    lrd_ir_remote i_lrd_ir_remote (.sys_clk(sys_clk), .key(key), .ir_on(ir_on), .ir_auto(ir_auto),
        .ir_off(ir_off), .ir_test(ir_test));
    lrd_ctrl i_lrd_ctrl (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ir_on(ir_on), .ir_auto(ir_auto),
        .ir_off(ir_off), .ir_test(ir_test), .limit_eval_enable(limit_eval_enable), .fb1_cmd_on(fb1_cmd_on),
        .fb1_cmd_auto(fb1_cmd_auto), .fb1_cmd_off(fb1_cmd_off), .walk_test(walk_test));
    // ----------
    // shared tasks
    // ----------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // read expectations go to the queue; the monitor below compares them
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
        if (!w)
            rq.push_back({m, d & m});
        avs_address <= a;
        avs_writedata <= w ? d : 32'h0;
        avs_read <= !w;
        avs_write <= w;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge sys_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic cmd(input logic [6:0] c);
        bus(1'b1, `LRD_OFS_CMD, {25'h0, c}, 32'h0);
    endtask
    // saved-copy bits are expected zero and masked off except in the reset check: only their effect after return matters
    task automatic stat(input logic el, input logic ei, input logic [31:0] m);
        bus(1'b0, `LRD_OFS_STATUS, {27'h0, ewalk, 2'b00, ei, el}, m);
        if (m[0])
            chk({31'h0, limit_eval_enable}, {31'h0, !el});
        chk({31'h0, walk_test}, {31'h0, ewalk});
    endtask
    always @(posedge sys_clk)
        if (avs_read && avs_waitrequest === 1'b0)
        begin
            rnote = rq.pop_front();
            chk(avs_readdata & rnote[63:32], rnote[31:0]);
        end
    always @(posedge sys_clk)
        if (fb1_cmd_on || fb1_cmd_auto || fb1_cmd_off)
            chk({29'h0, fb1_cmd_on, fb1_cmd_auto, fb1_cmd_off}, {29'h0, fq.pop_front()});
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        $display("unexpected at %0t: timeout", $time);
        test_done;
    end
    // ----------
    // scenarios
    // ----------
    initial
    begin
        int          i;
        logic        v;
        logic [1:0]  m;
        logic [13:0] c;
        logic [3:0]  k;
        logic [2:0]  e;
        logic        ok;
        logic [15:0] lv;
        void'($urandom(32'ha68d));
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, `LRD_OFS_CFG, 32'h0, 32'hffffffff);
        bus(1'b0, `LRD_OFS_LIMIT_VALUE, {16'h0, `LRD_LIMIT_RESET}, 32'hffffffff);
        bus(1'b1, 4'h2, 32'hffffffff, 32'h0);
        bus(1'b0, 4'h2, 32'h0, 32'hffffffff);
        stat(1'b0, 1'b0, 32'hffffffff);
        for (i = 0; i < 8; i++)
        begin
            bus(1'b1, `LRD_OFS_CFG, {21'h0, i[1], i[2], 7'h0, i[1], i[2]}, 32'h0);
            cmd({3'h0, i[0], 1'b1, i[0], 1'b1});
            v = i[2] & (i[0] ^ i[1]);
            stat(v, v, 32'h3);
        end
        for (i = 0; i < 8; i++)
        begin
            m = i[2:1];
            v = i[0];
            bus(1'b1, `LRD_OFS_CFG, {19'h0, m, 2'b01, 5'h0, m, 2'b01}, 32'h0);
            cmd({3'h0, v, 1'b1, v, 1'b1});
            cmd(7'h10);
            cmd({3'h0, !v, 1'b1, !v, 1'b1});
            cmd(7'h20);
            stat(m == 1 || (m == 2 && v), m == 1 || (m == 2 && v), 32'h3);
        end
        for (i = 0; i < 2; i++)
        begin
            bus(1'b1, `LRD_OFS_CFG, {18'h0, i[0], 4'h1, 4'h0, i[0], 4'h1}, 32'h0);
            cmd({3'h0, !i[0], 1'b1, !i[0], 1'b1});
            cmd(7'h40);
            stat(i[0], i[0], 32'h3);
        end
        lv = 16'($urandom);
        bus(1'b1, `LRD_OFS_LIMIT_VALUE, {16'h0, lv}, 32'h0);
        bus(1'b0, `LRD_OFS_LIMIT_VALUE, {16'h0, lv}, 32'hffffffff);
        for (i = 0; i < 80; i++)
        begin
            c = 14'($urandom);
            v = 1'($urandom);
            k = 4'($urandom);
            bus(1'b1, `LRD_OFS_CFG, {18'h0, c}, 32'h0);
            cmd({3'h0, v, 1'b1, 2'b00});
            ok = c[5] && !(c[9] && (v ^ c[10]));
            e = {k[0] && c[7:6] != 2'h2, k[1], k[2] && c[7:6] != 2'h1} & {3{ok}};
            if (e != 3'h0)
                fq.push_back(e);
            if (k[3] && ok && c[8])
                ewalk = !ewalk;
            key <= k;
            @(posedge sys_clk);
            key <= 4'h0;
            repeat (3) @(posedge sys_clk);
            stat(1'b0, 1'b0, 32'h10);
        end
        repeat (4) @(posedge sys_clk);
        chk(fq.size() + rq.size(), 32'h0);
        test_done;
    end
endmodule // lrd_ctrl_tb
